// ---- src/bpc_ctrl.sv ----
`timescale 1ns/100ps
`include "bpc_cfg.svh"

// Behaviour
// - each control register is 64 bits wide
// - unimplemented breakpoint system access is undefined; external access reads zero
// - low 32 bits match external view
// - bit 29 exists only with realm feature
// - mode and security fields decide jointly
// - control fields other than enable come up unknown after reset; enable resets to 0
// - type in 23:20; 0000 plain address match
// - 0001 address match plus linked context match
// - 0010 context id, hyp or kernel context
// - odd context types are linkable even ones
// - 0110 compares kernel context only
// - 1000 compares vm identifier
// - 1010 needs context and vm identifier
// - 1100 compares second id with hyp
// - 1110 needs both context ids equal
// - bits 19:16 name the linked breakpoint
// - link index ignored for other types
// - link index ignored while disabled
// - bits 15:14 select security states
// - bit 13 is the higher mode control
// - bits 2:1 select permitted levels
// - bit 0 enables the breakpoint
module bpc_ctrl
    import bpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic realm_feature,
    input wire logic host_virtualization_feature,
    input wire logic sys_req,
    input wire logic sys_write,
    input wire logic [`BPC_IDX_W-1:0] sys_index,
    input wire logic [`BPC_REG_W-1:0] sys_wdata,
    output logic [`BPC_REG_W-1:0] sys_rdata,
    output logic sys_done,
    output logic sys_undef,
    input wire logic ext_req,
    input wire logic ext_write,
    input wire logic [`BPC_IDX_W-1:0] ext_index,
    input wire logic [`BPC_EXT_W-1:0] ext_wdata,
    output logic [`BPC_EXT_W-1:0] ext_rdata,
    output logic ext_done,
    input wire logic pc_valid,
    input wire logic [`BPC_REG_W-1:0] pc,
    input wire bpc_level_e cur_level,
    input wire bpc_sec_e cur_sec,
    input wire logic host_flag,
    input wire logic general_trap_flag,
    input wire logic [31:0] kernel_context_reg,
    input wire logic [31:0] hyp_context_reg,
    input wire logic [`BPC_VIRTUAL_MACHINE_IDENT_W-1:0] virtual_machine_ident,
    input wire logic [`BPC_NUM_BP*`BPC_REG_W-1:0] breakpoint_value_reg,
    output logic [`BPC_NUM_BP-1:0] bp_hit
);
    // stored fields, one entry per breakpoint
    logic [3:0] bt_q [`BPC_NUM_BP]; // breakpoint_type
    logic [3:0] lbn_q [`BPC_NUM_BP]; // linked_bp_index
    logic [1:0] ssc_q [`BPC_NUM_BP]; // security_state_ctl
    logic security_state_ctl_ext_q [`BPC_NUM_BP]; // security_state_ctl_ext
    logic hmc_q [`BPC_NUM_BP]; // higher_mode_ctl
    logic [1:0] pmc_q [`BPC_NUM_BP]; // privilege_mode_ctl
    logic [`BPC_NUM_BP-1:0] en_q; // enable per breakpoint

    logic sys_impl; // system access hits a real breakpoint
    logic ext_impl; // external access hits a real breakpoint
    logic sys_wr; // system write that stores
    logic ext_wr; // external write that stores
    logic [`BPC_NUM_BP-1:0] addr_hit; // comparator outputs
    logic [`BPC_NUM_BP-1:0] ctx_hit;
    logic [`BPC_NUM_BP-1:0] cond_ok;
    logic [`BPC_NUM_BP-1:0] link_ok; // usable as link target
    logic [`BPC_NUM_BP-1:0] hit_d; // next hit vector
    logic [`BPC_REG_W-1:0] ext_img; // full image seen by external view

    // index is legal only below the implemented count
    function automatic logic is_impl(input logic [`BPC_IDX_W-1:0] idx);
        is_impl = {1'b0, idx} < (`BPC_IDX_W+1)'(`BPC_NUM_IMPL);
    endfunction

    // assemble the 64-bit read image of one breakpoint
    function automatic logic [`BPC_REG_W-1:0] pack_ctrl(
        input logic [`BPC_IDX_W-1:0] idx, input logic rme);
        logic [`BPC_REG_W-1:0] v;
        v = '0; // reserved ranges stay zero
        if (is_impl(idx)) begin
            v[`BPC_SECURITY_STATE_CTL_EXT_BIT] = rme & security_state_ctl_ext_q[idx];
            v[`BPC_BT_HI:`BPC_BT_LO] = bt_q[idx];
            // stored index returned even where it is ignored
            v[`BPC_LBN_HI:`BPC_LBN_LO] = lbn_q[idx];
            v[`BPC_SSC_HI:`BPC_SSC_LO] = ssc_q[idx];
            v[`BPC_HMC_BIT] = hmc_q[idx];
            // no 32-bit state here, so byte select reads all ones
            v[`BPC_BAS_HI:`BPC_BAS_LO] = `BPC_BAS_ONES;
            v[`BPC_PMC_HI:`BPC_PMC_LO] = pmc_q[idx];
            v[`BPC_EN_BIT] = en_q[idx];
        end
        pack_ctrl = v;
    endfunction

    // a linked context breakpoint: odd type from 3 upward
    function automatic logic is_link_ctx(input logic [3:0] bt);
        is_link_ctx = bt[0] && bt >= `BPC_BT_FIRST_LINKED;
    endfunction

    // a function result cannot be part-selected, so name it first
    assign ext_img = pack_ctrl(ext_index, realm_feature);
    assign sys_impl = is_impl(sys_index);
    assign ext_impl = is_impl(ext_index);
    assign sys_wr = sys_req && sys_write && sys_impl;
    // system port wins a same-cycle write to the same entry
    assign ext_wr = ext_req && ext_write && ext_impl &&
        !(sys_wr && sys_index == ext_index);

    // field storage with no reset: contents unknown after cold reset
    always_ff @(posedge core_clk) begin
        if (sys_wr) begin
            bt_q[sys_index] <= sys_wdata[`BPC_BT_HI:`BPC_BT_LO];
            lbn_q[sys_index] <= sys_wdata[`BPC_LBN_HI:`BPC_LBN_LO];
            ssc_q[sys_index] <= sys_wdata[`BPC_SSC_HI:`BPC_SSC_LO];
            security_state_ctl_ext_q[sys_index] <= realm_feature &
                sys_wdata[`BPC_SECURITY_STATE_CTL_EXT_BIT];
            hmc_q[sys_index] <= sys_wdata[`BPC_HMC_BIT];
            pmc_q[sys_index] <= sys_wdata[`BPC_PMC_HI:`BPC_PMC_LO];
        end
        // external view reaches the very same fields
        if (ext_wr) begin
            bt_q[ext_index] <= ext_wdata[`BPC_BT_HI:`BPC_BT_LO];
            lbn_q[ext_index] <= ext_wdata[`BPC_LBN_HI:`BPC_LBN_LO];
            ssc_q[ext_index] <= ext_wdata[`BPC_SSC_HI:`BPC_SSC_LO];
            security_state_ctl_ext_q[ext_index] <= realm_feature &
                ext_wdata[`BPC_SECURITY_STATE_CTL_EXT_BIT];
            hmc_q[ext_index] <= ext_wdata[`BPC_HMC_BIT];
            pmc_q[ext_index] <= ext_wdata[`BPC_PMC_HI:`BPC_PMC_LO];
        end
    end

    // enable is cleared by reset so nothing fires from garbage
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_q <= {`BPC_NUM_BP{`BPC_EN_RST}};
        end else begin
            if (sys_wr) begin
                en_q[sys_index] <= sys_wdata[`BPC_EN_BIT];
            end
            if (ext_wr) begin
                en_q[ext_index] <= ext_wdata[`BPC_EN_BIT];
            end
        end
    end

    // system register answer, one cycle after the request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sys_rdata <= '0;
            sys_done <= 1'b0;
            sys_undef <= 1'b0;
        end else begin
            sys_done <= sys_req;
            // unimplemented index is an undefined instruction
            sys_undef <= sys_req && !sys_impl;
            if (sys_req && !sys_write) begin
                sys_rdata <= pack_ctrl(sys_index, realm_feature);
            end
        end
    end

    // external view answer: low word of the same image
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ext_rdata <= '0;
            ext_done <= 1'b0;
        end else begin
            ext_done <= ext_req;
            if (ext_req && !ext_write) begin
                ext_rdata <= ext_img[`BPC_EXT_W-1:0];
            end
        end
    end

    // one comparator set per breakpoint
    for (genvar n = 0; n < `BPC_NUM_BP; n++) begin : g_bp
        bpc_match u_match (
            .breakpoint_type(bt_q[n]),
            .security_state_ctl(ssc_q[n]),
            .security_state_ctl_ext(security_state_ctl_ext_q[n]),
            .higher_mode_ctl(hmc_q[n]),
            .privilege_mode_ctl(pmc_q[n]),
            .breakpoint_value_reg(
                breakpoint_value_reg[n*`BPC_REG_W +: `BPC_REG_W]),
            .pc(pc),
            .cur_level(cur_level),
            .cur_sec(cur_sec),
            .host_virtualization_feature(host_virtualization_feature),
            .host_flag(host_flag),
            .general_trap_flag(general_trap_flag),
            .kernel_context_reg(kernel_context_reg),
            .hyp_context_reg(hyp_context_reg),
            .virtual_machine_ident(virtual_machine_ident),
            .addr_hit(addr_hit[n]),
            .ctx_hit(ctx_hit[n]),
            .cond_ok(cond_ok[n])
        );
        // a link target must be enabled, linkable and matching
        assign link_ok[n] = en_q[n] && is_link_ctx(bt_q[n]) &&
            ctx_hit[n];
    end

    // hit decode; unimplemented entries never fire
    always_comb begin
        hit_d = '0;
        for (int n = 0; n < `BPC_NUM_IMPL; n++) begin
            // disabled entry: no event, link index not even looked at
            if (en_q[n] && cond_ok[n] && pc_valid) begin
                unique case (bt_q[n])
                    `BPC_BT_ADDR: hit_d[n] = addr_hit[n];
                    // link index only consulted for this type
                    `BPC_BT_ADDR_LINK: hit_d[n] = addr_hit[n] &&
                        link_ok[lbn_q[n]];
                    // unlinked context types hit on their own
                    default: hit_d[n] = !bt_q[n][0] && ctx_hit[n];
                endcase
            end
        end
    end

    // registered hit vector toward the pipeline
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bp_hit <= '0;
        end else begin
            bp_hit <= hit_d;
        end
    end

endmodule // bpc_ctrl

// ---- src/bpc_cfg.svh ----
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH

// breakpoint count and how many of them exist in this build
`define BPC_NUM_BP 16
`define BPC_NUM_IMPL 6
`define BPC_IDX_W 4

// control register field layout
`define BPC_REG_W 64
`define BPC_EXT_W 32
`define BPC_SECURITY_STATE_CTL_EXT_BIT 29
`define BPC_BT_HI 23
`define BPC_BT_LO 20
`define BPC_LBN_HI 19
`define BPC_LBN_LO 16
`define BPC_SSC_HI 15
`define BPC_SSC_LO 14
`define BPC_HMC_BIT 13
`define BPC_BAS_HI 8
`define BPC_BAS_LO 5
`define BPC_BAS_ONES 4'hf
`define BPC_PMC_HI 2
`define BPC_PMC_LO 1
`define BPC_EN_BIT 0
`define BPC_EN_RST 1'h0

// paired value register layout
`define BPC_CID_HI 31
`define BPC_CID_LO 0
`define BPC_CID2_HI 63
`define BPC_CID2_LO 32
`define BPC_VIRTUAL_MACHINE_IDENT_HI 47
`define BPC_VIRTUAL_MACHINE_IDENT_LO 32
`define BPC_VIRTUAL_MACHINE_IDENT_W 16
`define BPC_VA_HI 63
`define BPC_VA_LO 2

// breakpoint type codes
`define BPC_BT_ADDR 4'h0
`define BPC_BT_ADDR_LINK 4'h1
`define BPC_BT_CID 4'h2
`define BPC_BT_CID_KERN 4'h6
`define BPC_BT_VIRTUAL_MACHINE_IDENT 4'h8
`define BPC_BT_VIRTUAL_MACHINE_IDENT_CID 4'ha
`define BPC_BT_CID2 4'hc
`define BPC_BT_FULL_CID 4'he
`define BPC_BT_FIRST_LINKED 4'h3

// security state control codes
`define BPC_SSC_ANY 2'h0
`define BPC_SSC_NONSEC 2'h1
`define BPC_SSC_SEC 2'h2

`endif

// ---- src/bpc_pkg.sv ----
package bpc_pkg;

    // current exception level of the core
    typedef enum logic [1:0] {
        BPC_USER_LEVEL,
        BPC_KERNEL_LEVEL,
        BPC_HYPERVISOR_LEVEL,
        BPC_MONITOR_LEVEL
    } bpc_level_e;

    // current security state of the core
    typedef enum logic [1:0] {
        BPC_NONSECURE,
        BPC_SECURE,
        BPC_ROOT,
        BPC_REALM
    } bpc_sec_e;

endpackage

// ---- src/bpc_match.sv ----
`timescale 1ns/100ps
`include "bpc_cfg.svh"

// per-breakpoint comparators, purely combinational
module bpc_match
    import bpc_pkg::*;
(
    input wire logic [3:0] breakpoint_type,
    input wire logic [1:0] security_state_ctl,
    input wire logic security_state_ctl_ext,
    input wire logic higher_mode_ctl,
    input wire logic [1:0] privilege_mode_ctl,
    input wire logic [`BPC_REG_W-1:0] breakpoint_value_reg,
    input wire logic [`BPC_REG_W-1:0] pc,
    input wire bpc_level_e cur_level,
    input wire bpc_sec_e cur_sec,
    input wire logic host_virtualization_feature,
    input wire logic host_flag,
    input wire logic general_trap_flag,
    input wire logic [31:0] kernel_context_reg,
    input wire logic [31:0] hyp_context_reg,
    input wire logic [`BPC_VIRTUAL_MACHINE_IDENT_W-1:0] virtual_machine_ident,
    output logic addr_hit,
    output logic ctx_hit,
    output logic cond_ok
);
    logic [31:0] stored_cid; // first context id of value reg
    logic [31:0] second_cid; // second context id of value reg
    logic [`BPC_VIRTUAL_MACHINE_IDENT_W-1:0] stored_virtual_machine_ident; // vm id of value reg
    logic use_hyp_ctx; // host mode selects hypervisor context
    logic cid_kern_eq; // first id against kernel context
    logic virtual_machine_ident_eq; // vm id against stage-2 base
    logic [3:0] bt_even; // type with its link bit dropped
    logic el_ok; // level permitted by mode fields
    logic sec_ok; // security state permitted

    assign stored_cid = breakpoint_value_reg[`BPC_CID_HI:`BPC_CID_LO];
    assign second_cid = breakpoint_value_reg[`BPC_CID2_HI:`BPC_CID2_LO];
    assign stored_virtual_machine_ident = breakpoint_value_reg[`BPC_VIRTUAL_MACHINE_IDENT_HI:`BPC_VIRTUAL_MACHINE_IDENT_LO];
    assign cid_kern_eq = stored_cid == kernel_context_reg;
    assign virtual_machine_ident_eq = stored_virtual_machine_ident == virtual_machine_ident;
    assign bt_even = {breakpoint_type[3:1], 1'b0};

    // host-mode view: hypervisor, or user under the general trap
    assign use_hyp_ctx = host_virtualization_feature && host_flag &&
        (cur_level == BPC_HYPERVISOR_LEVEL ||
         (cur_level == BPC_USER_LEVEL && general_trap_flag));

    // instruction address compare, word aligned
    assign addr_hit = breakpoint_value_reg[`BPC_VA_HI:`BPC_VA_LO] ==
        pc[`BPC_VA_HI:`BPC_VA_LO];

    // context-side compare, same for linked and unlinked form
    always_comb begin
        unique case (bt_even)
            `BPC_BT_CID: ctx_hit = stored_cid ==
                (use_hyp_ctx ? hyp_context_reg : kernel_context_reg);
            `BPC_BT_CID_KERN: ctx_hit = cid_kern_eq;
            `BPC_BT_VIRTUAL_MACHINE_IDENT: ctx_hit = virtual_machine_ident_eq;
            `BPC_BT_VIRTUAL_MACHINE_IDENT_CID: ctx_hit = cid_kern_eq && virtual_machine_ident_eq;
            `BPC_BT_CID2: ctx_hit = second_cid == hyp_context_reg;
            `BPC_BT_FULL_CID: ctx_hit = cid_kern_eq &&
                second_cid == hyp_context_reg;
            // address types and reserved codes never context-match
            default: ctx_hit = 1'b0;
        endcase
    end

    // level filter: user and kernel by mode bits, hyp by higher mode
    always_comb begin
        unique case (cur_level)
            BPC_USER_LEVEL: el_ok = privilege_mode_ctl[1];
            BPC_KERNEL_LEVEL: el_ok = privilege_mode_ctl[0];
            BPC_HYPERVISOR_LEVEL: el_ok = higher_mode_ctl;
            BPC_MONITOR_LEVEL: el_ok = 1'b0;
        endcase
    end

    // security filter; extended bit moves the nonsecure code to realm
    always_comb begin
        unique case (security_state_ctl)
            `BPC_SSC_NONSEC: sec_ok = security_state_ctl_ext ?
                cur_sec == BPC_REALM : cur_sec == BPC_NONSECURE;
            `BPC_SSC_SEC: sec_ok = cur_sec == BPC_SECURE;
            default: sec_ok = !security_state_ctl_ext;
        endcase
    end

    // all four fields decide jointly
    assign cond_ok = el_ok && sec_ok;

endmodule // bpc_match

// ---- dv/bpc_ctrl_monitor.sv ----
`timescale 1ns/100ps
`include "bpc_cfg.svh"

// watches access handshakes, read images and hit pulses
module bpc_ctrl_monitor (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic realm_feature,
    input wire logic sys_req,
    input wire logic sys_write,
    input wire logic [`BPC_IDX_W-1:0] sys_index,
    input wire logic [`BPC_REG_W-1:0] sys_rdata,
    input wire logic sys_done,
    input wire logic sys_undef,
    input wire logic ext_req,
    input wire logic ext_write,
    input wire logic [`BPC_IDX_W-1:0] ext_index,
    input wire logic [`BPC_EXT_W-1:0] ext_rdata,
    input wire logic ext_done,
    input wire logic pc_valid,
    input wire logic [`BPC_NUM_BP-1:0] bp_hit
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // index outside the implemented set
    logic bad_idx;
    assign bad_idx = sys_index >= `BPC_NUM_IMPL;

    AST_SYS_DONE: assert property (sys_req |=> sys_done)
        else $error("no done after system request");
    AST_EXT_DONE: assert property (ext_req |=> ext_done)
        else $error("no done after external request");
    AST_UNDEF: assert property (sys_req && bad_idx |=> sys_undef)
        else $error("missing undefined pulse");
    AST_DEF: assert property (sys_req && !bad_idx |=> !sys_undef)
        else $error("undefined pulse on implemented index");
    AST_UNDEF_RD: assert property (sys_req && !sys_write && bad_idx
        |=> sys_rdata == 64'h0) else $error("unimplemented read not zero");
    AST_RES0: assert property (
        (sys_rdata & 64'hffff_ffff_df00_1e18) == 64'h0)
        else $error("reserved bit reads nonzero");
    AST_EXT_BIT: assert property (sys_req && !sys_write
        && !realm_feature |=> !sys_rdata[`BPC_SECURITY_STATE_CTL_EXT_BIT])
        else $error("extended security bit set without feature");
    AST_LOW_MAP: assert property (sys_req && !sys_write && ext_req
        && !ext_write && ext_index == sys_index
        |=> ext_rdata == sys_rdata[31:0])
        else $error("views disagree on low word");
    AST_HI_IDLE: assert property (
        bp_hit[`BPC_NUM_BP-1:`BPC_NUM_IMPL] == '0)
        else $error("unimplemented breakpoint hit");
    AST_HIT_CAUSE: assert property (!pc_valid |=> bp_hit == '0)
        else $error("hit without an instruction checked");

    CV_UNDEF: cover property (sys_undef);
    CV_HIT: cover property (|bp_hit);
    CV_BOTH: cover property (sys_done && ext_done);
endmodule // bpc_ctrl_monitor

bind bpc_ctrl bpc_ctrl_monitor i_bpc_ctrl_monitor (.core_clk(core_clk),
    .rstn(rstn), .realm_feature(realm_feature), .sys_req(sys_req),
    .sys_write(sys_write), .sys_index(sys_index), .sys_rdata(sys_rdata),
    .sys_done(sys_done), .sys_undef(sys_undef), .ext_req(ext_req),
    .ext_write(ext_write), .ext_index(ext_index), .ext_rdata(ext_rdata),
    .ext_done(ext_done), .pc_valid(pc_valid), .bp_hit(bp_hit));

// ---- dv/bpc_core_model.sv ----
`timescale 1ns/100ps
`include "bpc_cfg.svh"

// core side: instruction stream and context state
module bpc_core_model
    import bpc_pkg::*;
(
    input wire logic core_clk,
    output logic pc_valid,
    output logic [`BPC_REG_W-1:0] pc,
    output bpc_level_e cur_level,
    output bpc_sec_e cur_sec,
    output logic host_flag,
    output logic general_trap_flag,
    output logic [31:0] kernel_context_reg,
    output logic [31:0] hyp_context_reg,
    output logic [`BPC_VIRTUAL_MACHINE_IDENT_W-1:0] virtual_machine_ident
);
    // quiet core at time zero
    initial begin
        pc_valid = 1'b0;
        pc = 64'h0;
        cur_level = BPC_KERNEL_LEVEL;
        cur_sec = BPC_NONSECURE;
        host_flag = 1'b0;
        general_trap_flag = 1'b0;
        kernel_context_reg = 32'h0;
        hyp_context_reg = 32'h0;
        virtual_machine_ident = 16'h0;
    end

    // context state, changed just after an edge
    task automatic ctx(input logic [31:0] k, input logic [31:0] h,
        input logic hf, input logic tg);
        kernel_context_reg = k;
        hyp_context_reg = h;
        virtual_machine_ident = h[15:0];
        host_flag = hf;
        general_trap_flag = tg;
    endtask

    // one instruction checked for one cycle
    task automatic fetch(input logic [63:0] a, input bpc_level_e l,
        input bpc_sec_e s);
        // one idle edge so back-to-back calls never retoggle in one step
        @(posedge core_clk);
        #1;
        pc_valid = 1'b1;
        pc = a;
        cur_level = l;
        cur_sec = s;
        @(posedge core_clk);
        #1;
        pc_valid = 1'b0;
        // stale address inverted so a late sample cannot match
        pc = ~a;
    endtask
endmodule // bpc_core_model

// ---- dv/breakpoint_control_decode_bench.sv ----
`timescale 1ns/100ps
`include "bpc_cfg.svh"

module breakpoint_control_decode_bench import bpc_pkg::*;;
    localparam logic [63:0] A = 64'h0000_1234_5678_9abc;
    localparam logic [31:0] K = 32'h0bad_cafe;
    localparam logic [31:0] H = 32'h0000_5a5a;
    logic core_clk, rstn, realm_feature, host_virtualization_feature;
    logic sys_req, sys_write, sys_done, sys_undef;
    logic ext_req, ext_write, ext_done, pc_valid;
    logic host_flag, general_trap_flag;
    logic [3:0] sys_index, ext_index;
    logic [63:0] sys_wdata, sys_rdata, pc;
    logic [31:0] ext_wdata, ext_rdata, kernel_context_reg, hyp_context_reg;
    logic [15:0] virtual_machine_ident, bp_hit;
    logic [1023:0] breakpoint_value_reg;
    bpc_level_e cur_level;
    bpc_sec_e cur_sec;
    int err_total, checked, cycles;

    bpc_ctrl i_bpc_ctrl (.core_clk, .rstn, .realm_feature,
        .host_virtualization_feature, .sys_req, .sys_write, .sys_index,
        .sys_wdata, .sys_rdata, .sys_done, .sys_undef, .ext_req, .ext_write,
        .ext_index, .ext_wdata, .ext_rdata, .ext_done, .pc_valid, .pc,
        .cur_level, .cur_sec, .host_flag, .general_trap_flag,
        .kernel_context_reg, .hyp_context_reg, .virtual_machine_ident,
        .breakpoint_value_reg, .bp_hit);
    bpc_core_model i_bpc_core_model (.core_clk, .pc_valid, .pc, .cur_level,
        .cur_sec, .host_flag, .general_trap_flag, .kernel_context_reg,
        .hyp_context_reg, .virtual_machine_ident);

    // free-running clock
    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    // hang guard, far above the few hundred cycles needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            test_done;
        end
    end

    task automatic test_done;
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // one access pulse; reads with x low go out on both views at once
    task automatic acc(input logic w, input logic x, input logic [3:0] i,
        input logic [63:0] d);
        // one idle edge so back-to-back calls never retoggle in one step
        @(posedge core_clk);
        #1;
        sys_req = !x;
        ext_req = x || !w;
        sys_write = w;
        ext_write = w;
        sys_index = i;
        ext_index = i;
        sys_wdata = d;
        ext_wdata = d[31:0];
        @(posedge core_clk);
        #1;
        sys_req = 1'b0;
        ext_req = 1'b0;
    endtask

    task automatic wr(input logic [3:0] i, input logic [63:0] d);
        acc(1'b1, 1'b0, i, d);
    endtask

    task automatic rd(input logic [3:0] i, input logic [63:0] e);
        acc(1'b0, 1'b0, i, 64'h0);
        chk({ext_done, sys_done, sys_undef},
            {2'h3, i >= `BPC_NUM_IMPL});
        chk(sys_rdata, e);
        chk({32'h0, ext_rdata}, {32'h0, e[31:0]});
    endtask

    task automatic hit(input logic [63:0] a, input bpc_level_e l,
        input bpc_sec_e s, input logic [15:0] e);
        i_bpc_core_model.fetch(a, l, s);
        chk({48'h0, bp_hit}, {48'h0, e});
    endtask

    // main sequence
    initial begin
        {rstn, realm_feature, host_virtualization_feature} = 3'h0;
        {sys_req, sys_write, ext_req, ext_write} = 4'h0;
        {sys_index, ext_index, sys_wdata, ext_wdata} = '0;
        breakpoint_value_reg = '0;
        breakpoint_value_reg[63:0] = A;
        breakpoint_value_reg[127:64] = {H, K};
        repeat (12) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        chk({48'h0, bp_hit}, 64'h0);
        // reserved bits, bit 29 and both views of the low word
        for (int r = 0; r < 2; r++) begin
            realm_feature = r[0];
            for (int i = 0; i < 2; i++) begin
                acc(1'b1, i[0], i[3:0], '1);
                rd(i[3:0], 64'h00ff_e1e7 | (64'(r) << 29));
            end
        end
        realm_feature = 1'b0;
        rd(4'h0, 64'h00ff_e1e7);
        wr(4'h6, '1);
        rd(4'h6, 64'h0);
        // plain address match, levels, security, enable
        wr(4'h1, 64'h6);
        wr(4'h0, 64'h7);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h1);
        hit(A + 4, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h0);
        hit(A, BPC_USER_LEVEL, BPC_NONSECURE, 16'h1);
        hit(A, BPC_HYPERVISOR_LEVEL, BPC_NONSECURE, 16'h0);
        wr(4'h0, 64'h3);
        hit(A, BPC_USER_LEVEL, BPC_NONSECURE, 16'h0);
        wr(4'h0, 64'h8007);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h0);
        hit(A, BPC_KERNEL_LEVEL, BPC_SECURE, 16'h1);
        wr(4'h0, 64'h6);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h0);
        // every type code, kernel context matching then mismatching
        for (int p = 0; p < 2; p++) begin
            i_bpc_core_model.ctx(K ^ p, H, 1'b0, 1'b0);
            for (int t = 0; t < 16; t++) begin
                wr(4'h1, (64'(t) << 20) | 64'h7);
                hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE,
                    ((p ? 16'h1100 : 16'h5544) >> t & 16'h1) << 1);
            end
        end
        // host view of the context id type
        host_virtualization_feature = 1'b1;
        i_bpc_core_model.ctx(H, K, 1'b1, 1'b1);
        wr(4'h1, 64'h0020_2007);
        hit(A, BPC_HYPERVISOR_LEVEL, BPC_NONSECURE, 16'h2);
        hit(A, BPC_USER_LEVEL, BPC_NONSECURE, 16'h2);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h0);
        i_bpc_core_model.ctx(H, K, 1'b1, 1'b0);
        hit(A, BPC_USER_LEVEL, BPC_NONSECURE, 16'h0);
        // linked address match through index 1
        i_bpc_core_model.ctx(K, H, 1'b0, 1'b0);
        wr(4'h1, 64'h0030_0007);
        wr(4'h0, 64'h0011_0007);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h1);
        wr(4'h0, 64'h0012_0007);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h0);
        wr(4'h0, 64'h0011_0006);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h0);
        wr(4'h0, 64'h0011_0007);
        i_bpc_core_model.ctx(K ^ 1, H, 1'b0, 1'b0);
        hit(A, BPC_KERNEL_LEVEL, BPC_NONSECURE, 16'h0);
        test_done;
    end
endmodule // breakpoint_control_decode_bench
